// File: rtl/pfc_metering_trim_regs.sv
// manufacturer status and trim register bank of the pfc controller
// assumes a management-bus front end issuing one-cycle read/write requests
// What this block does
// R01: report ac line period, 8 bits, read-only
// R02: report temperature result, 16-bit register, 12-bit format
// R03: offset trim bit 7 set means subtract
// R04: apply 7-bit offset trim magnitude
// R05: gain trim bit 7 set means negative
// R06: correct meter gain by 7-bit magnitude
// R07: low-line light coefficients only when select set
// R08: high-line light coefficients only when select set
// R09: averaged power over 16 line cycles, read-only
// R10: select clear keeps normal loop coefficients
`default_nettype none
`include "pfc_trim_defines.svh"
module pfc_metering_trim_regs
   import pfc_trim_pkg::*;
(
   // clock and reset
   input  wire logic        clk_sys_i,
   input  wire logic        rst_i,
   // management bus register port
   input  wire reg_req_s    req_i,
   output reg_rsp_s         rsp_o,
   // measurement inputs
   input  wire logic [7:0]  ac_line_period_i,
   input  wire logic [11:0] temperature_sensor_i,
   input  wire logic        cycle_valid_i,
   input  wire logic [15:0] cycle_power_i,
   // raw high-line meter reading
   input  wire logic [15:0] meter_raw_i,
   // current loop context
   input  wire logic        light_load_filter_sel_i,
   input  wire logic        high_line_i,
   input  wire logic        light_load_i,
   input  wire logic [7:0]  normal_gain_i,
   input  wire logic [7:0]  normal_zero_i,
   // outputs to the loop and meter
   output logic      [7:0]  loop_gain_o,
   output logic      [7:0]  loop_zero_o,
   output logic      [15:0] meter_trimmed_o
);
   // offset weight: one count is full scale/2048, i.e. 32 lsb of the 16-bit reading
   function automatic logic [16:0] apply_offset(input logic [15:0] v, input sign_mag_s t);
      logic [16:0] r;
      r = {1'b0, v};
      if (t.negative) r = r - {5'h00, t.magnitude, 5'h00}; // [R03] [R04]
      else            r = r + {5'h00, t.magnitude, 5'h00}; // [R03] [R04]
      return r;
   endfunction : apply_offset
   function automatic logic [15:0] sat16(input logic [16:0] r, input logic neg);
      if (r[16]) return neg ? 16'h0000 : 16'hffff;
      return r[15:0];
   endfunction : sat16
   logic [7:0]  off_reg, off_next, gain_reg, gain_next;
   logic [7:0]  gll_reg, gll_next, zll_reg, zll_next;
   logic [7:0]  ghl_reg, ghl_next, zhl_reg, zhl_next;
   logic [7:0]  lper_reg, lper_next;
   logic [15:0] temp_reg, temp_next;
   reg_rsp_s    rsp_reg, rsp_next;
   logic [7:0]  lg_reg, lg_next, lz_reg, lz_next;
   logic [15:0] mt_reg, mt_next;
   logic [15:0] avg_power;
   sign_mag_s   off_t, gain_t;
   logic [23:0] gain_prod;
   logic [15:0] gain_corr;
   logic [15:0] after_gain;
   pfc_power_averager #(
      .CYCLES (`POWER_AVG_CYCLES),
      .SHIFT  (`POWER_AVG_SHIFT)
   ) u_avg (
      .clk_sys_i     (clk_sys_i),
      .rst_i         (rst_i),
      .cycle_valid_i (cycle_valid_i),
      .cycle_power_i (cycle_power_i),
      .avg_power_o   (avg_power)
   );
   always_comb begin
      off_t  = sign_mag_s'(off_reg);
      gain_t = sign_mag_s'(gain_reg);
      // gain weight: magnitude * value / 2048 (0.0625/128 of reading)
      gain_prod = {8'h00, meter_raw_i} * {17'h00000, gain_t.magnitude}; // [R06]
      gain_corr = 16'(gain_prod >> 11); // [R06]
      if (gain_t.negative) after_gain = sat16(17'({1'b0, meter_raw_i}) - 17'({1'b0, gain_corr}), 1'b1); // [R05]
      else                 after_gain = sat16(17'({1'b0, meter_raw_i}) + 17'({1'b0, gain_corr}), 1'b0); // [R05]
      mt_next = sat16(apply_offset(after_gain, off_t), off_t.negative);
   end
   always_comb begin
      lg_next = normal_gain_i; // [R10]
      lz_next = normal_zero_i; // [R10]
      if (light_load_i && light_load_filter_sel_i) begin
         if (high_line_i) begin
            lg_next = ghl_reg; // [R08]
            lz_next = zhl_reg; // [R08]
         end else begin
            lg_next = gll_reg; // [R07]
            lz_next = zll_reg; // [R07]
         end
      end
   end
   always_comb begin
      off_next  = off_reg;
      gain_next = gain_reg;
      gll_next  = gll_reg;
      zll_next  = zll_reg;
      ghl_next  = ghl_reg;
      zhl_next  = zhl_reg;
      lper_next = ac_line_period_i; // [R01]
      temp_next = {4'h0, temperature_sensor_i}; // [R02]
      rsp_next  = '0;
      if (req_i.wr) begin
         rsp_next.ack = 1'b1;
         case (req_i.addr)
            `OFS_METER_OFFSET_TRIM_HL: off_next  = req_i.wdata[7:0];
            `OFS_METER_GAIN_TRIM_HL:   gain_next = req_i.wdata[7:0];
            `OFS_LOOP_GAIN_LL_LIGHT:   gll_next  = req_i.wdata[7:0];
            `OFS_LOOP_ZERO_LL_LIGHT:   zll_next  = req_i.wdata[7:0];
            `OFS_LOOP_GAIN_HL_LIGHT:   ghl_next  = req_i.wdata[7:0];
            `OFS_LOOP_ZERO_HL_LIGHT:   zhl_next  = req_i.wdata[7:0];
            default:                   rsp_next.err = 1'b1;
         endcase
      end else if (req_i.rd) begin
         rsp_next.ack = 1'b1;
         case (req_i.addr)
            `OFS_AC_LINE_PERIOD:       rsp_next.rdata = {8'h00, lper_reg}; // [R01]
            `OFS_TEMPERATURE_ADC:      rsp_next.rdata = temp_reg; // [R02]
            `OFS_METER_OFFSET_TRIM_HL: rsp_next.rdata = {8'h00, off_reg};
            `OFS_METER_GAIN_TRIM_HL:   rsp_next.rdata = {8'h00, gain_reg};
            `OFS_LOOP_GAIN_LL_LIGHT:   rsp_next.rdata = {8'h00, gll_reg};
            `OFS_LOOP_ZERO_LL_LIGHT:   rsp_next.rdata = {8'h00, zll_reg};
            `OFS_LOOP_GAIN_HL_LIGHT:   rsp_next.rdata = {8'h00, ghl_reg};
            `OFS_LOOP_ZERO_HL_LIGHT:   rsp_next.rdata = {8'h00, zhl_reg};
            `OFS_AVERAGED_POWER:       rsp_next.rdata = avg_power; // [R09]
            default:                   rsp_next.err   = 1'b1;
         endcase
      end
   end
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         off_reg  <= `TRIM_RESET;
         gain_reg <= `TRIM_RESET;
         gll_reg  <= `COEF_RESET;
         zll_reg  <= `COEF_RESET;
         ghl_reg  <= `COEF_RESET;
         zhl_reg  <= `COEF_RESET;
         lper_reg <= 8'h00;
         temp_reg <= 16'h0000;
         rsp_reg  <= '0;
         lg_reg   <= 8'h00;
         lz_reg   <= 8'h00;
         mt_reg   <= 16'h0000;
      end else begin
         off_reg  <= off_next;
         gain_reg <= gain_next;
         gll_reg  <= gll_next;
         zll_reg  <= zll_next;
         ghl_reg  <= ghl_next;
         zhl_reg  <= zhl_next;
         lper_reg <= lper_next;
         temp_reg <= temp_next;
         rsp_reg  <= rsp_next;
         lg_reg   <= lg_next;
         lz_reg   <= lz_next;
         mt_reg   <= mt_next;
      end
   end
   assign rsp_o           = rsp_reg;
   assign loop_gain_o     = lg_reg;
   assign loop_zero_o     = lz_reg;
   assign meter_trimmed_o = mt_reg;
endmodule : pfc_metering_trim_regs
`default_nettype wire

// File: rtl/pfc_trim_defines.svh
// register offsets, field positions, reset values and timing figures of the trim bank
// assumes inclusion by bare name from design files
`ifndef PFC_TRIM_DEFINES_SVH
`define PFC_TRIM_DEFINES_SVH
`define OFS_AC_LINE_PERIOD        16'hfe85
`define OFS_TEMPERATURE_ADC       16'hfe86
`define OFS_METER_OFFSET_TRIM_HL  16'hfe8e
`define OFS_METER_GAIN_TRIM_HL    16'hfe8f
`define OFS_LOOP_GAIN_LL_LIGHT    16'hfe90
`define OFS_LOOP_ZERO_LL_LIGHT    16'hfe91
`define OFS_LOOP_GAIN_HL_LIGHT    16'hfe92
`define OFS_LOOP_ZERO_HL_LIGHT    16'hfe93
`define OFS_AVERAGED_POWER        16'hfe94
`define TRIM_SIGN_BIT             7
`define TRIM_MAG_MSB              6
`define TRIM_RESET                8'h00
`define COEF_RESET                8'h00
`define PERIOD_LSB_NS             163840
`define TEMP_ADC_BITS             12
`define POWER_AVG_CYCLES          16
`define POWER_AVG_SHIFT           4
`endif

// File: rtl/pfc_trim_pkg.sv
// types shared by the trim bank
// assumes the defines header is compiled first
`default_nettype none
package pfc_trim_pkg;
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [15:0] wdata;
   } reg_req_s;
   typedef struct packed {
      logic        ack;
      logic        err;
      logic [15:0] rdata;
   } reg_rsp_s;
   typedef struct packed {
      logic       negative;
      logic [6:0] magnitude;
   } sign_mag_s;
   typedef enum logic [1:0] {
      AVG_IDLE  = 2'b00,
      AVG_ACCUM = 2'b01,
      AVG_DONE  = 2'b10
   } avg_state_e;
endpackage : pfc_trim_pkg
`default_nettype wire

// File: rtl/pfc_power_averager.sv
// averages per-line-cycle power samples over a block of cycles
// assumes one sample strobe per complete ac line cycle
`default_nettype none
`include "pfc_trim_defines.svh"
module pfc_power_averager
   import pfc_trim_pkg::*;
#(
   parameter int CYCLES = `POWER_AVG_CYCLES,
   parameter int SHIFT  = `POWER_AVG_SHIFT
) (
   // clock and reset
   input  wire logic        clk_sys_i,
   input  wire logic        rst_i,
   // samples
   input  wire logic        cycle_valid_i,
   input  wire logic [15:0] cycle_power_i,
   // result
   output logic      [15:0] avg_power_o
);
   // the counter and accumulator widths serve at most 16 cycles
   if (((1 << SHIFT) != CYCLES) || (SHIFT > 4) || (SHIFT < 1)) begin : g_bad_params
      $error("CYCLES must equal 2**SHIFT with SHIFT in 1..4");
   end
   logic [19:0] acc_reg, acc_next;
   logic [4:0]  cnt_reg, cnt_next;
   logic [15:0] avg_reg, avg_next;
   avg_state_e  st_reg, st_next;
   always_comb begin
      acc_next = acc_reg;
      cnt_next = cnt_reg;
      avg_next = avg_reg;
      st_next  = st_reg;
      case (st_reg)
         AVG_IDLE: begin
            acc_next = 20'h00000;
            cnt_next = 5'h00;
            st_next  = AVG_ACCUM;
         end
         AVG_ACCUM: begin
            if (cycle_valid_i) begin
               acc_next = acc_reg + {4'h0, cycle_power_i};
               cnt_next = cnt_reg + 5'h01;
               if (cnt_reg == 5'(CYCLES - 1)) st_next = AVG_DONE;
            end
         end
         AVG_DONE: begin
            avg_next = 16'(acc_reg >> SHIFT); // [R09]
            st_next  = AVG_IDLE;
         end
         default: st_next = AVG_IDLE;
      endcase
   end
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         acc_reg <= 20'h00000;
         cnt_reg <= 5'h00;
         avg_reg <= 16'h0000;
         st_reg  <= AVG_IDLE;
      end else begin
         acc_reg <= acc_next;
         cnt_reg <= cnt_next;
         avg_reg <= avg_next;
         st_reg  <= st_next;
      end
   end
   assign avg_power_o = avg_reg;
endmodule : pfc_power_averager
`default_nettype wire

// File: verif/pfc_trim_regs_sva.sv
// port timing assertions for the trim register bank
// assumes it is bound onto pfc_metering_trim_regs
`default_nettype none
module pfc_trim_regs_sva
   import pfc_trim_pkg::*;
(
   // clock and reset
   input wire logic       clk_sys_i,
   input wire logic       rst_i,
   // register port
   input wire reg_req_s   req_i,
   input wire reg_rsp_s   rsp_o,
   // loop context
   input wire logic       light_load_filter_sel_i,
   input wire logic       light_load_i,
   input wire logic [7:0] normal_gain_i,
   input wire logic [7:0] normal_zero_i,
   input wire logic [7:0] loop_gain_o,
   input wire logic [7:0] loop_zero_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   wire logic take = req_i.wr | req_i.rd;
   AST_ACK_NEXT: assert property (take |=> rsp_o.ack) else $error("no ack after request");
   AST_ACK_PULSE: assert property (!take |=> !rsp_o.ack && !rsp_o.err) else $error("stray ack");
   AST_PERIOD_RO: assert property (req_i.wr && req_i.addr == 16'hfe85 |=> rsp_o.err) else $error("period writable");
   AST_POWER_RO: assert property (req_i.wr && req_i.addr == 16'hfe94 |=> rsp_o.err) else $error("power writable");
   AST_PERIOD_WIDTH: assert property (req_i.rd && !req_i.wr && req_i.addr == 16'hfe85
      |=> rsp_o.rdata[15:8] == 8'h00) else $error("period upper byte set");
   AST_TEMP_WIDTH: assert property (req_i.rd && !req_i.wr && req_i.addr == 16'hfe86
      |=> rsp_o.rdata[15:12] == 4'h0) else $error("temperature above 12 bits");
   AST_NORMAL_GAIN: assert property (!light_load_filter_sel_i
      |=> loop_gain_o == $past(normal_gain_i)) else $error("gain not normal");
   AST_NORMAL_ZERO: assert property (!light_load_i
      |=> loop_zero_o == $past(normal_zero_i)) else $error("zero not normal");
   cover property (take && req_i.wr);
   cover property (rsp_o.err);
   cover property (light_load_filter_sel_i && light_load_i);
endmodule : pfc_trim_regs_sva
`default_nettype wire

// File: verif/pfc_host_model.sv
// host model issuing one-cycle register requests
// assumes the bank registers its answer on the taking edge, before the next falling edge
`default_nettype none
module pfc_host_model
   import pfc_trim_pkg::*;
(
   // clock
   input  wire logic     clk_sys_i,
   // register port
   output reg_req_s      req_o,
   input  wire reg_rsp_s rsp_i
);
   timeunit 1ns;
   timeprecision 1ns;
   initial req_o = '0;
   task automatic access(input logic wr, input logic [15:0] a, input logic [15:0] d, output reg_rsp_s r);
      @(posedge clk_sys_i);
      req_o <= '{wr: wr, rd: !wr, addr: a, wdata: d};
      @(posedge clk_sys_i);
      req_o <= '0;
      @(negedge clk_sys_i);
      r = rsp_i;
   endtask : access
endmodule : pfc_host_model
`default_nettype wire

// File: verif/pfc_metering_trim_regs_test.sv
// self-checking bench for the trim register bank
// assumes host model and checker are compiled first
`default_nettype none
module pfc_metering_trim_regs_test
   import pfc_trim_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_sys_i = 0, rst_i = 1, cv = 0, sel = 0, hl = 0, ll = 0;
   logic [7:0]  period = 8'hc3, ng = 8'h5a, nz = 8'ha6, lg, lz;
   logic [11:0] temp = 12'habc;
   logic [15:0] cp = 16'h0000, raw = 16'h8000, mt;
   reg_req_s    req;
   reg_rsp_s    rsp, r;
   int          bad_count = 0, checks = 0;
   pfc_metering_trim_regs pfc_metering_trim_regs_i (.clk_sys_i, .rst_i, .req_i(req), .rsp_o(rsp),
      .ac_line_period_i(period), .temperature_sensor_i(temp), .cycle_valid_i(cv), .cycle_power_i(cp),
      .meter_raw_i(raw), .light_load_filter_sel_i(sel), .high_line_i(hl), .light_load_i(ll),
      .normal_gain_i(ng), .normal_zero_i(nz), .loop_gain_o(lg), .loop_zero_o(lz), .meter_trimmed_o(mt));
   pfc_host_model pfc_host_model_i (.clk_sys_i, .req_o(req), .rsp_i(rsp));
   always #50 clk_sys_i = ~clk_sys_i;
   task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s exp %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic acc(logic wr, logic [15:0] a, logic [15:0] d);
      pfc_host_model_i.access(wr, a, d, r);
   endtask : acc
   task automatic t_rw;
      for (int a = 16'hfe8e; a <= 16'hfe93; a++) begin
         acc(0, a[15:0], 16'h0);
         chk("reset", r.rdata, 16'h0000);
         acc(1, a[15:0], {8'hff, a[7:0]});
         acc(0, a[15:0], 16'h0);
         chk("rw", r.rdata, {8'h00, a[7:0]});
      end
   endtask : t_rw
   task automatic t_ro;
      acc(0, 16'hfe85, 16'h0);
      chk("period", r.rdata, 16'h00c3);
      acc(0, 16'hfe86, 16'h0);
      chk("temp", r.rdata, 16'h0abc);
      acc(1, 16'hfe85, 16'h0011);
      chk("period err", {15'h0, r.err}, 16'h0001);
      acc(1, 16'hfe94, 16'h0011);
      chk("power err", {15'h0, r.err}, 16'h0001);
      acc(0, 16'hfe95, 16'h0);
      chk("unmapped err", {15'h0, r.err}, 16'h0001);
   endtask : t_ro
   task automatic t_loop;
      logic u;
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_sys_i) {sel, hl, ll} <= i[2:0];
         repeat (2) @(posedge clk_sys_i);
         @(negedge clk_sys_i);
         u = sel & ll;
         chk("gain", {8'h0, lg}, {8'h0, u ? (hl ? 8'h92 : 8'h90) : ng});
         chk("zero", {8'h0, lz}, {8'h0, u ? (hl ? 8'h93 : 8'h91) : nz});
      end
   endtask : t_loop
   task automatic t_meter;
      logic [31:0] tb [4] = '{32'h0500_80a0, 32'h8500_7f60, 32'h0010_8100, 32'h0090_7f00};
      @(posedge clk_sys_i) hl <= 1;
      foreach (tb[i]) begin
         acc(1, 16'hfe8e, {8'h0, tb[i][31:24]});
         acc(1, 16'hfe8f, {8'h0, tb[i][23:16]});
         repeat (3) @(posedge clk_sys_i);
         @(negedge clk_sys_i);
         chk("meter", mt, tb[i][15:0]);
      end
   endtask : t_meter
   task automatic t_avg;
      for (int k = 1; k <= 16; k++) begin
         @(posedge clk_sys_i) {cv, cp} <= {1'b1, 16'(k * 16)};
         @(posedge clk_sys_i) cv <= 0;
      end
      repeat (3) @(posedge clk_sys_i);
      acc(0, 16'hfe94, 16'h0);
      chk("power", r.rdata, 16'h0088);
   endtask : t_avg
   task automatic end_sim;
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : end_sim
   initial begin
      #500000;
      bad_count++;
      end_sim();
   end
   initial begin
      repeat (16) @(posedge clk_sys_i);
      rst_i <= 0;
      t_rw();
      t_ro();
      t_loop();
      t_meter();
      t_avg();
      end_sim();
   end
endmodule : pfc_metering_trim_regs_test
bind pfc_metering_trim_regs pfc_trim_regs_sva pfc_trim_regs_sva_i (.clk_sys_i, .rst_i, .req_i, .rsp_o,
   .light_load_filter_sel_i, .light_load_i, .normal_gain_i, .normal_zero_i, .loop_gain_o, .loop_zero_o);
`default_nettype wire
